// ==== dual_section_register.sv ====
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1 - Two independent nine-bit sections, each with own clock, gate, clear, enable.
// RULE2 - Gate low and clear released: capture data on rising capture clock.
// RULE3 - Gate high: capture clock edges ignored, contents held.
// RULE4 - Clear low forces every bit of its section to zero at once.
// RULE5 - Enable low drives stored bits out; enable high turns outputs off.
// RULE6 - Output enable never alters stored bits; capture and clear still work.
// RULE7 - Driving logic uses active-low controls and a rising-edge capture clock.
// RULE8 - Floating data inputs keep their last driven level.
// RULE9 - Clear wins over a simultaneous enabled capture edge.

module dual_section_register
   import section_reg_pkg::*;
(
   // Clock and reset
   input  wire logic                                 CLOCK,
   input  wire logic                                 RESETN,
   // Section A controls
   input  wire logic                                 SECTION_A_CAPTURE_CLOCK,
   input  wire logic                                 SECTION_A_CLOCK_GATE_N,
   input  wire logic                                 SECTION_A_CLEAR_N,
   input  wire logic                                 SECTION_A_OUTPUT_ENABLE_N,
   // Section A data
   input  wire logic [section_reg_pkg::SECTION_WIDTH-1:0] SECTION_A_DATA_IN,
   input  wire logic [section_reg_pkg::SECTION_WIDTH-1:0] SECTION_A_DATA_IN_DRIVEN,
   output logic      [section_reg_pkg::SECTION_WIDTH-1:0] SECTION_A_DATA_OUT,
   output logic      [section_reg_pkg::SECTION_WIDTH-1:0] SECTION_A_DATA_OUT_EN,
   // Section B controls
   input  wire logic                                 SECTION_B_CAPTURE_CLOCK,
   input  wire logic                                 SECTION_B_CLOCK_GATE_N,
   input  wire logic                                 SECTION_B_CLEAR_N,
   input  wire logic                                 SECTION_B_OUTPUT_ENABLE_N,
   // Section B data
   input  wire logic [section_reg_pkg::SECTION_WIDTH-1:0] SECTION_B_DATA_IN,
   input  wire logic [section_reg_pkg::SECTION_WIDTH-1:0] SECTION_B_DATA_IN_DRIVEN,
   output logic      [section_reg_pkg::SECTION_WIDTH-1:0] SECTION_B_DATA_OUT,
   output logic      [section_reg_pkg::SECTION_WIDTH-1:0] SECTION_B_DATA_OUT_EN
);
   import section_reg_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // An undriven bit keeps what it last saw while driven
   function automatic logic [SECTION_WIDTH-1:0] bus_hold
   (
      input logic [SECTION_WIDTH-1:0] pin,
      input logic [SECTION_WIDTH-1:0] driven,
      input logic [SECTION_WIDTH-1:0] held
   );
      bus_hold = (pin & driven) | (held & ~driven);
   endfunction

   // ****************************************************************
   // Pin gathering
   // ****************************************************************
   logic [CTRL_WIDTH-1:0]    ctrl_pin     [SECTION_COUNT];
   logic [SECTION_WIDTH-1:0] data_pin     [SECTION_COUNT];
   logic [SECTION_WIDTH-1:0] driven_pin   [SECTION_COUNT];
   logic [SECTION_WIDTH-1:0] stored       [SECTION_COUNT];
   logic [SECTION_WIDTH-1:0] out_en       [SECTION_COUNT];

   assign ctrl_pin[0]   = {SECTION_A_OUTPUT_ENABLE_N, SECTION_A_CLEAR_N,
                           SECTION_A_CLOCK_GATE_N, SECTION_A_CAPTURE_CLOCK};
   assign ctrl_pin[1]   = {SECTION_B_OUTPUT_ENABLE_N, SECTION_B_CLEAR_N,
                           SECTION_B_CLOCK_GATE_N, SECTION_B_CAPTURE_CLOCK};
   assign data_pin[0]   = SECTION_A_DATA_IN;
   assign data_pin[1]   = SECTION_B_DATA_IN;
   assign driven_pin[0] = SECTION_A_DATA_IN_DRIVEN;
   assign driven_pin[1] = SECTION_B_DATA_IN_DRIVEN;

   assign SECTION_A_DATA_OUT    = stored[0];
   assign SECTION_A_DATA_OUT_EN = out_en[0];
   assign SECTION_B_DATA_OUT    = stored[1];
   assign SECTION_B_DATA_OUT_EN = out_en[1];

   // ****************************************************************
   // Sections
   // ****************************************************************
   // Identical, fully separate sections; only CLOCK and RESETN are shared between them
   for (genvar s = 0; s < SECTION_COUNT; s++)
   begin : g_section // RULE1
      logic [CTRL_WIDTH-1:0]      ctrl;
      logic [2*SECTION_WIDTH-1:0] data_level;
      logic [SECTION_WIDTH-1:0]   held;
      logic [SECTION_WIDTH-1:0]   next_held;
      logic [SECTION_WIDTH-1:0]   next_stored;
      logic                       clock_prev;
      logic                       capture_edge;

      // Data travels through the same depth as the controls so that the
      // value captured is the one present at the capture edge
      pin_filter
      #(
         .WIDTH       (CTRL_WIDTH),
         .RESET_VALUE (CTRL_IDLE)
      )
      u_ctrl_filter
      (
         .clock  (CLOCK),
         .resetn (RESETN),
         .pin    (ctrl_pin[s]),
         .level  (ctrl)
      );

      pin_filter
      #(
         .WIDTH       (2*SECTION_WIDTH),
         .RESET_VALUE ({DATA_ZERO, DATA_ZERO})
      )
      u_data_filter
      (
         .clock  (CLOCK),
         .resetn (RESETN),
         .pin    ({driven_pin[s], data_pin[s]}),
         .level  (data_level)
      );

      assign next_held = bus_hold(data_level[SECTION_WIDTH-1:0],
                                  data_level[2*SECTION_WIDTH-1:SECTION_WIDTH], held); // RULE8

      always_ff @(posedge CLOCK)
      begin
         if (!RESETN)
            held <= DATA_ZERO;
         else
            held <= next_held; // RULE8
      end

      always_ff @(posedge CLOCK)
      begin
         if (!RESETN)
            clock_prev <= 1'b0;
         else
            clock_prev <= ctrl[CTRL_CAPTURE_CLK];
      end

      // RULE7
      assign capture_edge = ctrl[CTRL_CAPTURE_CLK] & ~clock_prev;

      // Output enable is deliberately absent from this decision
      always_comb
      begin
         next_stored = stored[s];
         if (!ctrl[CTRL_CLEAR_N])
            next_stored = DATA_ZERO; // RULE4 RULE9
         else if (capture_edge && !ctrl[CTRL_GATE_N])
            next_stored = next_held; // RULE2
         // Gate high: edge ignored, contents kept  // RULE3
      end

      always_ff @(posedge CLOCK)
      begin
         if (!RESETN)
            stored[s] <= DATA_ZERO;
         else
            stored[s] <= next_stored; // RULE6
      end

      always_ff @(posedge CLOCK)
      begin
         if (!RESETN)
            out_en[s] <= DATA_ZERO;
         else
            out_en[s] <= {SECTION_WIDTH{~ctrl[CTRL_OE_N]}}; // RULE5
      end
   end
endmodule

`default_nettype wire

// ==== pin_filter.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Constants shared by the register sections
// ****************************************************************
package section_reg_pkg;
   localparam int SECTION_WIDTH = 9;
   localparam int SECTION_COUNT = 2;
   // Positions of the control pins inside one filtered control word
   localparam int CTRL_WIDTH       = 4;
   localparam int CTRL_CAPTURE_CLK = 0;
   localparam int CTRL_GATE_N      = 1;
   localparam int CTRL_CLEAR_N     = 2;
   localparam int CTRL_OE_N        = 3;
   // Idle pin levels: gate closed, clear released, outputs off, clock low
   localparam logic [CTRL_WIDTH-1:0]    CTRL_IDLE  = 4'he;
   localparam logic [SECTION_WIDTH-1:0] DATA_ZERO  = 9'h000;
endpackage

// ****************************************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************************************
module pin_filter
#(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             resetn,
   // Raw pins and filtered levels
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] agree;

   // Stage1 feeds stage2 only; the filter looks at stages 2 and 3
   assign agree = ~(stage2 ^ stage3);

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         stage1 <= RESET_VALUE;
         stage2 <= RESET_VALUE;
         stage3 <= RESET_VALUE;
      end
      else
      begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
         level <= RESET_VALUE;
      else
         level <= (level & ~agree) | (stage3 & agree);
   end
endmodule

`default_nettype wire

// ==== section_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ***
// Port checks
// ***
module section_chk
   import section_reg_pkg::*;
(
   // Clock and reset
   input wire logic                     CLOCK,
   input wire logic                     RESETN,
   // Section A
   input wire logic                     SECTION_A_CAPTURE_CLOCK,
   input wire logic                     SECTION_A_CLOCK_GATE_N,
   input wire logic                     SECTION_A_CLEAR_N,
   input wire logic                     SECTION_A_OUTPUT_ENABLE_N,
   input wire logic [SECTION_WIDTH-1:0] SECTION_A_DATA_OUT,
   input wire logic [SECTION_WIDTH-1:0] SECTION_A_DATA_OUT_EN,
   // Section B
   input wire logic                     SECTION_B_CLEAR_N,
   input wire logic [SECTION_WIDTH-1:0] SECTION_B_DATA_OUT
);
   wire logic                     cl = SECTION_A_CLEAR_N;
   wire logic                     oe = SECTION_A_OUTPUT_ENABLE_N;
   wire logic [SECTION_WIDTH-1:0] q  = SECTION_A_DATA_OUT;
   wire logic [SECTION_WIDTH-1:0] en = SECTION_A_DATA_OUT_EN;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   // Seven cycles cover the four-flop pin filter and the output register
   property p_oe_on; (!oe)[*7] |-> en == '1; endproperty
   a_oe_on: assert property (p_oe_on) else $error("bus not driven");
   property p_oe_off; oe[*7] |-> en == '0; endproperty
   a_oe_off: assert property (p_oe_off) else $error("bus not released");
   property p_uniform; en == '0 || en == '1; endproperty
   a_uniform: assert property (p_uniform) else $error("mixed enables");
   property p_steady; $stable(oe)[*7] |-> $stable(en); endproperty
   a_steady: assert property (p_steady) else $error("enable moved");
   property p_clear; (!cl)[*7] |-> q == '0; endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");
   property p_gate; (cl && SECTION_A_CLOCK_GATE_N)[*7] |-> $stable(q); endproperty
   a_gate: assert property (p_gate) else $error("gated section changed");
   property p_no_edge; (cl && !SECTION_A_CAPTURE_CLOCK)[*7] |-> $stable(q); endproperty
   a_no_edge: assert property (p_no_edge) else $error("change without edge");
   property p_b_clear; (!SECTION_B_CLEAR_N)[*7] |-> SECTION_B_DATA_OUT == '0; endproperty
   a_b_clear: assert property (p_b_clear) else $error("b clear ignored");
   c_clear_edge: cover property (!cl && $rose(SECTION_A_CAPTURE_CLOCK));
   c_gated_edge: cover property (SECTION_A_CLOCK_GATE_N && $rose(SECTION_A_CAPTURE_CLOCK));
   c_hidden: cover property (oe && q != '0);
endmodule
`default_nettype wire

// ==== bus_receiver.sv ====
`timescale 1ns/1ps
`default_nettype none
// ***
// Bus receiver
// ***
module bus_receiver
   import section_reg_pkg::*;
(
   // Clock and bus
   input wire logic                     clock,
   input wire logic [SECTION_WIDTH-1:0] q,
   input wire logic [SECTION_WIDTH-1:0] en,
   output logic     [SECTION_WIDTH-1:0] level
);
   logic [SECTION_WIDTH-1:0] last = '0;
   // No pull on the bus: a released bit flips every cycle so stale data never passes
   assign level = (q & en) | (~last & ~en);
   always_ff @(posedge clock) last <= level;
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ***
// Random traffic on both sections
// ***
module tb;
   import section_reg_pkg::*;
   typedef logic [SECTION_WIDTH-1:0] word_t;
   logic  CLOCK = 1'b0;
   logic  RESETN = 1'b0;
   logic  cc [2], gn [2], cl [2], oe [2], g, c, o;
   word_t din [2], drv [2], q [2], en [2], lvl [2], hold [2], exq [2], d, dv;
   int    s;
   int    fail_count = 0;
   int    comparisons = 0;
   dual_section_register i_dut (.CLOCK(CLOCK), .RESETN(RESETN),
      .SECTION_A_CAPTURE_CLOCK(cc[0]), .SECTION_A_CLOCK_GATE_N(gn[0]), .SECTION_A_CLEAR_N(cl[0]),
      .SECTION_A_OUTPUT_ENABLE_N(oe[0]), .SECTION_A_DATA_IN(din[0]), .SECTION_A_DATA_IN_DRIVEN(drv[0]),
      .SECTION_A_DATA_OUT(q[0]), .SECTION_A_DATA_OUT_EN(en[0]),
      .SECTION_B_CAPTURE_CLOCK(cc[1]), .SECTION_B_CLOCK_GATE_N(gn[1]), .SECTION_B_CLEAR_N(cl[1]),
      .SECTION_B_OUTPUT_ENABLE_N(oe[1]), .SECTION_B_DATA_IN(din[1]), .SECTION_B_DATA_IN_DRIVEN(drv[1]),
      .SECTION_B_DATA_OUT(q[1]), .SECTION_B_DATA_OUT_EN(en[1]));
   bus_receiver i_rx0 (.clock(CLOCK), .q(q[0]), .en(en[0]), .level(lvl[0]));
   bus_receiver i_rx1 (.clock(CLOCK), .q(q[1]), .en(en[1]), .level(lvl[1]));
   initial forever #4 CLOCK = ~CLOCK;
   // Bus hold: floating bits keep the last driven level
   function automatic word_t resolve(word_t dat, word_t drive, word_t held);
      return (dat & drive) | (held & ~drive);
   endfunction
   task automatic check(string name, word_t want, word_t got);
      comparisons++;
      if (got !== want)
      begin
         $display("unexpected %s expected %h seen %h", name, want, got);
         fail_count++;
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      foreach (cc[k])
      begin
         {cc[k], gn[k], cl[k], oe[k]} = 4'h7;
         {din[k], drv[k], hold[k], exq[k]} = '0;
      end
      void'($urandom(55));
      repeat (5) @(posedge CLOCK);
      RESETN <= 1'b1;
      @(posedge CLOCK);
      foreach (q[k])
         check("reset data", '0, q[k] | en[k]);
      $display("test reset done");
      for (int i = 0; i < 40; i++)
      begin
         s = int'($urandom % 2);
         d = word_t'($urandom);
         dv = (i % 3 == 0) ? 9'h1ff : (i % 3 == 1) ? 9'h000 : word_t'($urandom);
         g = (i % 5 == 4);
         c = (i % 4 == 3);
         o = 1'($urandom);
         din[s] <= (d & dv) | (~din[s] & ~dv);
         drv[s] <= dv;
         gn[s] <= g;
         cl[s] <= !c;
         oe[s] <= o;
         hold[s] = resolve(d, dv, hold[s]);
         exq[s] = c ? '0 : (g ? exq[s] : hold[s]);
         repeat (3) @(posedge CLOCK);
         cc[s] <= 1'b1;
         repeat (4) @(posedge CLOCK);
         cc[s] <= 1'b0;
         repeat (4) @(posedge CLOCK);
         check("stored", exq[s], q[s]);
         check("other section", exq[1-s], q[1-s]);
         check("enable", {SECTION_WIDTH{!o}}, en[s]);
         if (!o)
            check("bus", exq[s], lvl[s]);
         cl[s] <= 1'b1;
         repeat (4) @(posedge CLOCK);
         $display("test %0d done", i);
      end
      tally_and_finish();
   end
endmodule
bind dual_section_register section_chk i_chk (.*);
`default_nettype wire
